/* core/ssd_decoder.sv */
// slave and bus-error status decoder with its register file
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A slave byte sent and acked gives vector 0100, no ack request, no arbitration loss, ack flag set.
// - A slave byte sent with an error gives vector 0100 with arbitration-lost set.
// - An illegal stop or bus error in slave transmit gives vector 0101 with no ack request.
// - A matched slave address gives vector 0010 with ack request set and no arbitration loss.
// - An address after lost master arbitration gives 0010 with ack request and arbitration-lost set.
// - A stop while addressed as slave gives vector 0001 with both flags clear.
// - Lost arbitration while sending a stop gives 0001 with both flags set.
// - A received slave byte gives vector 0000 with an ack request.
// - Lost arbitration on a repeated start gives 0010 with only arbitration-lost set.
// - Lost arbitration on a detected stop gives 0001 with only arbitration-lost set.
// - Lost arbitration on a master data byte gives 0000 with both flags set.
// - The vector is master mode, transmit direction, start and stop request bits.
// - A nacked slave address mutes slave events until the next start.
module ssd_decoder (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       ce,
	input  wire logic [ssd_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [ssd_pkg::AXI_DW-1:0] wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [ssd_pkg::AXI_AW-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [ssd_pkg::AXI_DW-1:0]      rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic                       ev_valid,
	input  wire ssd_pkg::ssd_ev_t           ev_code,
	input  wire logic                       ev_rw,
	input  wire logic                       ev_ack,
	input  wire logic                       ev_arb,
	input  wire logic [ssd_pkg::BYTE_W-1:0] rx_byte,
	output logic                            scl_hold,
	output logic                            ack_out,
	output logic                            start_req,
	output logic                            stop_req,
	output logic [ssd_pkg::BYTE_W-1:0]      tx_data,
	output logic                            irq
);
	import ssd_pkg::*;

	ssd_reg_if rif ();

	logic              master_mode_r;
	logic              transmit_direction_flag_r;
	logic              start_request_bit_r;
	logic              stop_request_bit_r;
	logic              ack_request_flag_r;
	logic              arbitration_lost_flag_r;
	logic              ack_r;
	logic              si_r;
	logic [BYTE_W-1:0] smbus_data_reg_r;
	logic [IRQ_W-1:0]  istat_r;
	logic [IRQ_W-1:0]  imask_r;
	logic              irq_r;
	ssd_sl_t           sl_r;
	ssd_sl_t           sl_nxt;
	logic              dec_take, dec_ackreq, dec_arb, dec_ack, dec_err;
	logic [3:0]        dec_vec;

	// ========================================
	// bus slave
	ssd_axil_slave u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rif     (rif)
	);

	// ========================================
	// event decode
	wire sl_tx = sl_r == SL_TX;
	wire sl_rx = sl_r == SL_RX;
	wire sl_in = sl_r == SL_INHIB;
	always_comb begin
		dec_take   = 1'b0;
		dec_vec    = VEC_SLV_RX;
		dec_ackreq = 1'b0;
		dec_arb    = 1'b0;
		dec_ack    = ack_r;
		dec_err    = 1'b0;
		unique case (ev_code)
			EV_START: begin
				dec_take = 1'b0;
			end
			EV_ADDR: begin
				dec_take   = !sl_in;
				dec_vec    = VEC_ADDR;
				dec_ackreq = 1'b1;
				dec_arb    = ev_arb;
			end
			EV_TX_DONE: begin
				dec_take = sl_tx;
				dec_vec  = VEC_SLV_TX;
				dec_ack  = ev_ack;
			end
			EV_TX_ERR: begin
				dec_take = sl_tx;
				dec_vec  = VEC_SLV_TX;
				dec_arb  = 1'b1;
				dec_err  = 1'b1;
			end
			EV_BUS_ERR: begin
				dec_take = sl_tx;
				dec_vec  = VEC_BUS_ERR;
				dec_err  = 1'b1;
			end
			EV_STOP: begin
				dec_take = sl_tx || sl_rx;
				dec_vec  = VEC_STOP;
			end
			EV_ARB_STOP: begin
				dec_take   = 1'b1;
				dec_vec    = VEC_STOP;
				dec_ackreq = 1'b1;
				dec_arb    = 1'b1;
				dec_err    = 1'b1;
			end
			EV_RX_BYTE: begin
				dec_take   = sl_rx;
				dec_vec    = VEC_SLV_RX;
				dec_ackreq = 1'b1;
			end
			EV_ARB_RSTART: begin
				dec_take = 1'b1;
				dec_vec  = VEC_ADDR;
				dec_arb  = 1'b1;
				dec_err  = 1'b1;
			end
			EV_ARB_STOPDET: begin
				dec_take = 1'b1;
				dec_vec  = VEC_STOP;
				dec_arb  = 1'b1;
				dec_err  = 1'b1;
			end
			EV_ARB_DATA: begin
				dec_take   = 1'b1;
				dec_vec    = VEC_SLV_RX;
				dec_ackreq = 1'b1;
				dec_arb    = 1'b1;
				dec_err    = 1'b1;
			end
			default: begin
				dec_take = 1'b0;
			end
		endcase
	end

	// ========================================
	// register writes and next values
	wire       ev_take  = ce && ev_valid && dec_take;
	wire       w_ctrl   = rif.wr && rif.widx == IDX_CTRL;
	wire       w_data   = rif.wr && rif.widx == IDX_DATA;
	wire       w_istat  = rif.wr && rif.widx == IDX_ISTAT;
	wire       w_imask  = rif.wr && rif.widx == IDX_IMASK;
	wire [3:0] vec      = {master_mode_r, transmit_direction_flag_r,
	                       start_request_bit_r, stop_request_bit_r};
	wire [3:0] fw_vec   = {master_mode_r, transmit_direction_flag_r,
	                       rif.wdata[CB_START], rif.wdata[CB_STOP]};
	wire       si_clr   = w_ctrl && !rif.wdata[CB_SI];
	wire       nack_rel = si_clr && si_r && vec == VEC_ADDR &&
	                      ack_request_flag_r && !rif.wdata[CB_ACK];
	wire       start_in = ce && ev_valid && ev_code == EV_START;
	wire [3:0] vec_nxt  = ev_take ? dec_vec : w_ctrl ? fw_vec : vec;
	wire       ack_nxt  = ev_take ? dec_ack :
	                      w_ctrl ? rif.wdata[CB_ACK] : ack_r;
	wire       si_nxt   = ev_take ? 1'b1 : si_clr ? 1'b0 : si_r;
	wire       rx_take  = ev_take && ev_code == EV_RX_BYTE;
	wire [BYTE_W-1:0] data_nxt = rx_take ? rx_byte :
	                      w_data ? rif.wdata : smbus_data_reg_r;
	wire [IRQ_W-1:0] clr_bits = w_istat ? rif.wdata[IRQ_W-1:0] : IRQ_RST;
	wire [IRQ_W-1:0] set_bits = {ev_take && dec_err, ev_take};
	wire [IRQ_W-1:0] istat_nxt = (istat_r & ~clr_bits) | set_bits;
	wire [IRQ_W-1:0] imask_nxt = w_imask ? rif.wdata[IRQ_W-1:0] : imask_r;
	wire             addr_in   = ev_take && ev_code == EV_ADDR;
	wire             leave     = ev_take && (ev_code == EV_STOP ||
	                             ev_code == EV_BUS_ERR);

	always_comb begin
		sl_nxt = sl_r;
		if (start_in && sl_in) begin
			sl_nxt = SL_IDLE;
		end else if (nack_rel) begin
			sl_nxt = SL_INHIB;
		end else if (addr_in) begin
			sl_nxt = ev_rw ? SL_TX : SL_RX;
		end else if (leave) begin
			sl_nxt = SL_IDLE;
		end
	end

	// ========================================
	// state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{master_mode_r, transmit_direction_flag_r} <= VEC_RST[3:2];
			{start_request_bit_r, stop_request_bit_r}  <= VEC_RST[1:0];
			ack_request_flag_r      <= 1'b0;
			arbitration_lost_flag_r <= 1'b0;
			ack_r                   <= 1'b0;
			si_r                    <= 1'b0;
			sl_r                    <= SL_IDLE;
		end else if (ce) begin
			{master_mode_r, transmit_direction_flag_r} <= vec_nxt[3:2];
			{start_request_bit_r, stop_request_bit_r}  <= vec_nxt[1:0];
			if (ev_take) begin
				ack_request_flag_r      <= dec_ackreq;
				arbitration_lost_flag_r <= dec_arb;
			end
			ack_r <= ack_nxt;
			si_r  <= si_nxt;
			sl_r  <= sl_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smbus_data_reg_r <= DATA_RST;
			istat_r          <= IRQ_RST;
			imask_r          <= IRQ_RST;
			irq_r            <= 1'b0;
		end else if (ce) begin
			smbus_data_reg_r <= data_nxt;
			istat_r          <= istat_nxt;
			imask_r          <= imask_nxt;
			irq_r            <= |(istat_nxt & imask_nxt);
		end
	end

	// ========================================
	// read mux and outputs
	wire [7:0] ctrl_rd = {vec, ack_request_flag_r,
	                      arbitration_lost_flag_r, ack_r, si_r};
	assign rif.rdata = rif.ridx == IDX_CTRL  ? ctrl_rd :
	                   rif.ridx == IDX_DATA  ? smbus_data_reg_r :
	                   rif.ridx == IDX_ISTAT ? {IRQ_PAD, istat_r} :
	                                           {IRQ_PAD, imask_r};
	assign scl_hold  = si_r;
	assign ack_out   = ack_r;
	assign start_req = start_request_bit_r;
	assign stop_req  = stop_request_bit_r;
	assign tx_data   = smbus_data_reg_r;
	assign irq       = irq_r;

	// ========================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_take(ssd_ev_t c);
		ev_take && ev_code == c;
	endsequence
	sequence s_nack_rel;
		ce && nack_rel;
	endsequence
	wire slave_ev = ev_code inside {EV_ADDR, EV_TX_DONE, EV_TX_ERR,
	                EV_BUS_ERR, EV_STOP, EV_RX_BYTE};
	wire [1:0] flags = {ack_request_flag_r, arbitration_lost_flag_r};

	tx_ack_a : assert property (
		s_take(EV_TX_DONE) ##0 ev_ack |=> vec == VEC_SLV_TX &&
		flags == 2'h0 && ack_r && si_r)
		else $error("slave tx ack state wrong");
	tx_err_a : assert property (
		s_take(EV_TX_ERR) |=> vec == VEC_SLV_TX && flags == 2'h1)
		else $error("slave tx error state wrong");
	bus_err_a : assert property (
		s_take(EV_BUS_ERR) |=> vec == VEC_BUS_ERR &&
		!ack_request_flag_r && sl_r == SL_IDLE)
		else $error("bus error state wrong");
	addr_match_a : assert property (
		s_take(EV_ADDR) ##0 !ev_arb |=> vec == VEC_ADDR && flags == 2'h2)
		else $error("address state wrong");
	addr_arb_a : assert property (
		s_take(EV_ADDR) ##0 ev_arb |=> vec == VEC_ADDR && flags == 2'h3)
		else $error("lost-arbitration address state wrong");
	slave_stop_a : assert property (
		s_take(EV_STOP) |=> vec == VEC_STOP && flags == 2'h0 &&
		sl_r == SL_IDLE)
		else $error("slave stop state wrong");
	stop_arb_a : assert property (
		s_take(EV_ARB_STOP) |=> vec == VEC_STOP && flags == 2'h3)
		else $error("stop attempt loss state wrong");
	rx_byte_a : assert property (
		s_take(EV_RX_BYTE) |=> vec == VEC_SLV_RX && flags == 2'h2 &&
		smbus_data_reg_r == $past(rx_byte))
		else $error("slave rx state wrong");
	rstart_arb_a : assert property (
		s_take(EV_ARB_RSTART) |=> vec == VEC_ADDR && flags == 2'h1)
		else $error("repeated start loss state wrong");
	stopdet_arb_a : assert property (
		s_take(EV_ARB_STOPDET) |=> vec == VEC_STOP && flags == 2'h1)
		else $error("stop detect loss state wrong");
	data_arb_a : assert property (
		s_take(EV_ARB_DATA) |=> vec == VEC_SLV_RX && flags == 2'h3)
		else $error("data byte loss state wrong");
	vec_read_a : assert property (
		ev_take ##1 rif.ridx == IDX_CTRL |->
		rif.rdata[CB_VEC_MSB:CB_VEC_LSB] == $past(dec_vec))
		else $error("status vector read wrong");
	nack_mute_a : assert property (
		s_nack_rel |=> sl_r == SL_INHIB && !si_r)
		else $error("nacked address did not mute");
	mute_hold_a : assert property (
		sl_in && ev_valid && slave_ev |-> !dec_take)
		else $error("muted slave event taken");
	flag_hold_a : assert property (
		ev_take |=> si_r && scl_hold ##1 (si_r || $past(si_clr)))
		else $error("serial flag not held");
endmodule // ssd_decoder
`default_nettype wire

/* core/ssd_pkg.sv */
// shared constants and types for the status decoder
`default_nettype none
package ssd_pkg;
	// ========================================
	// bus
	localparam int         AXI_AW      = 8;
	localparam int         AXI_DW      = 32;
	localparam int         BYTE_W      = 8;
	localparam int         IDX_LSB     = 2;
	localparam int         MAP_LSB     = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [23:0] RD_PAD     = 24'h000000;
	// ========================================
	// register map
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_DATA    = 8'h04;
	localparam logic [7:0] OFF_ISTAT   = 8'h08;
	localparam logic [7:0] OFF_IMASK   = 8'h0C;
	localparam logic [1:0] IDX_CTRL    = OFF_CTRL[3:2];
	localparam logic [1:0] IDX_DATA    = OFF_DATA[3:2];
	localparam logic [1:0] IDX_ISTAT   = OFF_ISTAT[3:2];
	localparam logic [1:0] IDX_IMASK   = OFF_IMASK[3:2];
	// ========================================
	// control register fields
	localparam int         CB_SI       = 0;
	localparam int         CB_ACK      = 1;
	localparam int         CB_ARB      = 2;
	localparam int         CB_ACKREQ   = 3;
	localparam int         CB_STOP     = 4;
	localparam int         CB_START    = 5;
	localparam int         CB_VEC_LSB  = 4;
	localparam int         CB_VEC_MSB  = 7;
	// ========================================
	// interrupt fields and reset values
	localparam int         IB_STATE    = 0;
	localparam int         IB_ERR      = 1;
	localparam int         IRQ_W       = 2;
	localparam logic [7:0] DATA_RST    = 8'h00;
	localparam logic [3:0] VEC_RST     = 4'h0;
	localparam logic [1:0] IRQ_RST     = 2'h0;
	localparam logic [5:0] IRQ_PAD     = 6'h00;
	// ========================================
	// status vectors
	localparam logic [3:0] VEC_SLV_RX  = 4'h0;
	localparam logic [3:0] VEC_STOP    = 4'h1;
	localparam logic [3:0] VEC_ADDR    = 4'h2;
	localparam logic [3:0] VEC_SLV_TX  = 4'h4;
	localparam logic [3:0] VEC_BUS_ERR = 4'h5;
	// ========================================
	// bus engine events and slave states
	typedef enum logic [3:0] {
		EV_START       = 4'h0,
		EV_ADDR        = 4'h1,
		EV_TX_DONE     = 4'h2,
		EV_TX_ERR      = 4'h3,
		EV_BUS_ERR     = 4'h4,
		EV_STOP        = 4'h5,
		EV_ARB_STOP    = 4'h6,
		EV_RX_BYTE     = 4'h7,
		EV_ARB_RSTART  = 4'h8,
		EV_ARB_STOPDET = 4'h9,
		EV_ARB_DATA    = 4'hA
	} ssd_ev_t;
	typedef enum logic [1:0] {
		SL_IDLE  = 2'h0,
		SL_RX    = 2'h1,
		SL_TX    = 2'h2,
		SL_INHIB = 2'h3
	} ssd_sl_t;
endpackage
`default_nettype wire

/* core/ssd_reg_if.sv */
// register access carrier between bus slave and decoder core
`timescale 1ns/1ps
`default_nettype none
interface ssd_reg_if;
	logic       wr;
	logic [1:0] widx;
	logic [7:0] wdata;
	logic [1:0] ridx;
	logic [7:0] rdata;
	modport bus  (output wr, widx, wdata, ridx, input rdata);
	modport core (input wr, widx, wdata, ridx, output rdata);
endinterface
`default_nettype wire

/* core/ssd_axil_slave.sv */
// axi4-lite slave front end for the decoder registers
`timescale 1ns/1ps
`default_nettype none
module ssd_axil_slave (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       ce,
	input  wire logic [ssd_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [ssd_pkg::AXI_DW-1:0] wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [ssd_pkg::AXI_AW-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [ssd_pkg::AXI_DW-1:0]      rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	ssd_reg_if.bus                          rif
);
	import ssd_pkg::*;

	logic [AXI_AW-1:0] awaddr_r;
	logic [7:0]        wdata_r;
	logic              wstrb0_r;
	logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [AXI_DW-1:0] rdata_r;
	wire               aw_hs = awvalid && awready_r;
	wire               w_hs  = wvalid && wready_r;
	wire               b_hs  = bvalid_r && bready;
	wire               ar_hs = arvalid && arready_r;
	wire               r_hs  = rvalid_r && rready;
	wire               wr_go = !awready_r && !wready_r && !bvalid_r;
	wire               w_hit = awaddr_r[AXI_AW-1:MAP_LSB] == '0 &&
	                           awaddr_r[IDX_LSB-1:0] == '0;
	wire               r_hit = araddr[AXI_AW-1:MAP_LSB] == '0 &&
	                           araddr[IDX_LSB-1:0] == '0;

	// ========================================
	// decode toward the core
	assign rif.wr    = wr_go && w_hit && wstrb0_r;
	assign rif.widx  = awaddr_r[MAP_LSB-1:IDX_LSB];
	assign rif.wdata = wdata_r;
	assign rif.ridx  = araddr[MAP_LSB-1:IDX_LSB];

	// ========================================
	// write channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			awaddr_r  <= '0;
			wdata_r   <= DATA_RST;
			wstrb0_r  <= 1'b0;
		end else if (ce) begin
			if (aw_hs) begin
				awready_r <= 1'b0;
				awaddr_r  <= awaddr;
			end
			if (w_hs) begin
				wready_r <= 1'b0;
				wdata_r  <= wdata[BYTE_W-1:0];
				wstrb0_r <= wstrb[0];
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_hs) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// ========================================
	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= r_hit ? {RD_PAD, rif.rdata} : '0;
				rresp_r   <= r_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (r_hs) begin
				arready_r <= 1'b1;
				rvalid_r  <= 1'b0;
			end
		end
	end

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
endmodule // ssd_axil_slave
`default_nettype wire

/* sim/ssd_bus_master_model.sv */
// event source standing in for the external bus master
`timescale 1ns/1ps
`default_nettype none
// ========================================
// partner model
module ssd_bus_master_model (
	input  wire logic             aclk,
	output var  logic             ev_valid,
	output var  ssd_pkg::ssd_ev_t ev_code,
	output var  logic             ev_rw,
	output var  logic             ev_ack,
	output var  logic             ev_arb,
	output var  logic [7:0]       rx_byte
);
	import ssd_pkg::*;
	initial begin
		ev_valid = 1'b0;
		ev_code = EV_START;
		ev_rw = 1'b0;
		ev_ack = 1'b0;
		ev_arb = 1'b0;
		rx_byte = 8'h00;
	end
	// one event per call; fields are scrambled once it is gone
	task automatic send(input ssd_ev_t c, input logic rw, input logic ak,
		input logic ab, input logic [7:0] b);
		@(posedge aclk);
		ev_valid <= 1'b1;
		ev_code <= c;
		ev_rw <= rw;
		ev_ack <= ak;
		ev_arb <= ab;
		rx_byte <= b;
		@(posedge aclk);
		ev_valid <= 1'b0;
		ev_code <= ssd_ev_t'(~c);
		ev_rw <= ~rw;
		ev_ack <= ~ak;
		ev_arb <= ~ab;
		rx_byte <= ~b;
	endtask
endmodule // ssd_bus_master_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the status decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ssd_pkg::*;
	logic        aclk;
	logic        ce;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [1:0]  rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        ev_valid, ev_rw, ev_ack, ev_arb;
	ssd_ev_t     ev_code;
	logic [7:0]  rx_byte;
	logic [7:0]  tx_data;
	logic        scl_hold, ack_out, start_req, stop_req, irq;
	int          n_fail;
	int          samples_checked;
	// ========================================
	// design and partner
	ssd_decoder dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ev_valid(ev_valid), .ev_code(ev_code), .ev_rw(ev_rw),
		.ev_ack(ev_ack), .ev_arb(ev_arb), .rx_byte(rx_byte),
		.scl_hold(scl_hold), .ack_out(ack_out), .start_req(start_req),
		.stop_req(stop_req), .tx_data(tx_data), .irq(irq));
	ssd_bus_master_model bm (.aclk(aclk), .ev_valid(ev_valid),
		.ev_code(ev_code), .ev_rw(ev_rw), .ev_ack(ev_ack),
		.ev_arb(ev_arb), .rx_byte(rx_byte));
	always #4 aclk = ~aclk;
	// ========================================
	// helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang();
		n_fail++;
		$display("[ERR] bus answer expected 1 seen none");
		end_of_test();
	endtask
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (bvalid === 1'b1) begin
				rs = bresp;
				return;
			end
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		hang();
	endtask
	task automatic axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (rvalid === 1'b1) begin
				rd = rdata;
				rs = rresp;
				return;
			end
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		hang();
	endtask
	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		axr(a);
		chk(nm, e, rd & m);
	endtask
	// ========================================
	// scenarios
	task automatic t_regs();
		rc("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rc("istat", OFF_ISTAT, 32'hFFFFFFFF, 32'h0);
		axw(OFF_DATA, 8'hA5);
		rc("data", OFF_DATA, 32'hFFFFFFFF, 32'hA5);
		chk("tx_data", 32'hA5, 32'(tx_data));
		axr(8'h10);
		chk("rd resp", 32'(RESP_SLVERR), 32'(rs));
		chk("rd zero", 32'h0, rd);
		axw(8'h14, 8'h01);
		chk("wr resp", 32'(RESP_SLVERR), 32'(rs));
	endtask
	task automatic t_rx();
		bm.send(EV_ADDR, 1'b0, 1'b0, 1'b0, 8'h00);
		rc("addr wr", OFF_CTRL, 32'hFC, 32'h28);
		chk("hold", 32'h1, 32'(scl_hold));
		axw(OFF_CTRL, 8'h02);
		chk("ack_out", 32'h1, 32'(ack_out));
		chk("release", 32'h0, 32'(scl_hold));
		bm.send(EV_RX_BYTE, 1'b0, 1'b0, 1'b0, 8'h5A);
		rc("rx byte", OFF_CTRL, 32'hFC, 32'h08);
		rc("rx data", OFF_DATA, 32'hFF, 32'h5A);
		axw(OFF_CTRL, 8'h02);
		bm.send(EV_STOP, 1'b0, 1'b0, 1'b0, 8'h00);
		rc("stop", OFF_CTRL, 32'hFC, 32'h10);
		chk("stop_req", 32'h1, 32'(stop_req));
		axw(OFF_CTRL, 8'h00);
		chk("stop clr", 32'h0, 32'(stop_req));
	endtask
	task automatic t_tx();
		bm.send(EV_ADDR, 1'b1, 1'b0, 1'b0, 8'h00);
		rc("addr rd", OFF_CTRL, 32'hFC, 32'h28);
		axw(OFF_DATA, 8'h3C);
		axw(OFF_CTRL, 8'h02);
		chk("tx_data", 32'h3C, 32'(tx_data));
		bm.send(EV_TX_DONE, 1'b1, 1'b1, 1'b0, 8'h00);
		rc("tx ack", OFF_CTRL, 32'hFE, 32'h42);
		axw(OFF_CTRL, 8'h02);
		bm.send(EV_TX_DONE, 1'b1, 1'b0, 1'b0, 8'h00);
		rc("tx nack", OFF_CTRL, 32'hFE, 32'h40);
		axw(OFF_CTRL, 8'h02);
		bm.send(EV_TX_ERR, 1'b1, 1'b0, 1'b0, 8'h00);
		rc("tx err", OFF_CTRL, 32'hFC, 32'h44);
		axw(OFF_CTRL, 8'h02);
		bm.send(EV_BUS_ERR, 1'b1, 1'b0, 1'b0, 8'h00);
		rc("bus err", OFF_CTRL, 32'hF8, 32'h50);
		axw(OFF_CTRL, 8'h00);
		chk("stop clr", 32'h0, 32'(stop_req));
	endtask
	task automatic t_arb();
		ssd_ev_t    c[5] = '{EV_ADDR, EV_ARB_STOP, EV_ARB_RSTART,
			EV_ARB_STOPDET, EV_ARB_DATA};
		logic [7:0] e[5] = '{8'h2C, 8'h1C, 8'h24, 8'h14, 8'h0C};
		for (int i = 0; i < 5; i++) begin
			bm.send(c[i], 1'b0, 1'b0, 1'b1, 8'h00);
			rc("arb", OFF_CTRL, 32'hFC, 32'(e[i]));
			axw(OFF_CTRL, 8'h22);
			chk("start_req", 32'h1, 32'(start_req));
		end
		rc("istat", OFF_ISTAT, 32'hFF, 32'h03);
	endtask
	task automatic t_mute();
		axw(OFF_ISTAT, 8'h03);
		axw(OFF_IMASK, 8'h00);
		bm.send(EV_START, 1'b0, 1'b0, 1'b0, 8'h00);
		bm.send(EV_ADDR, 1'b0, 1'b0, 1'b0, 8'h00);
		rc("istat", OFF_ISTAT, 32'hFF, 32'h01);
		chk("irq off", 32'h0, 32'(irq));
		axw(OFF_IMASK, 8'h01);
		@(posedge aclk);
		chk("irq on", 32'h1, 32'(irq));
		axw(OFF_ISTAT, 8'h01);
		@(posedge aclk);
		chk("irq clr", 32'h0, 32'(irq));
		axw(OFF_CTRL, 8'h00);
		bm.send(EV_ADDR, 1'b0, 1'b0, 1'b0, 8'h00);
		rc("muted", OFF_ISTAT, 32'hFF, 32'h00);
		chk("muted hold", 32'h0, 32'(scl_hold));
		bm.send(EV_START, 1'b0, 1'b0, 1'b0, 8'h00);
		bm.send(EV_ADDR, 1'b0, 1'b0, 1'b0, 8'h00);
		rc("unmuted", OFF_CTRL, 32'hFC, 32'h28);
		chk("hold", 32'h1, 32'(scl_hold));
	endtask
	task automatic t_ce();
		axw(OFF_CTRL, 8'h02);
		ce <= 1'b0;
		bm.send(EV_ARB_DATA, 1'b0, 1'b0, 1'b1, 8'h00);
		ce <= 1'b1;
		@(posedge aclk);
		chk("ce hold", 32'h0, 32'(scl_hold));
	endtask
	// ========================================
	// main sequence
	initial begin
		n_fail = 0;
		samples_checked = 0;
		aclk = 1'b0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		ce = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_rx();
		t_tx();
		t_arb();
		t_mute();
		t_ce();
		end_of_test();
	end
endmodule // tb
`default_nettype wire
